// ### bench/ccd_frontend_mode_control_monitor.sv
module ccd_frontend_mode_control_monitor (
   // Clock, reset and bus
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [9:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic        wb_ack_o,
   // Pins and state
   input wire logic        line_sync_i,
   input wire logic        frame_sync_i,
   input wire logic [9:0]  gain_code_o,
   input wire logic [18:0] gain_db_o,
   input wire logic        ref_standby_o,
   input wire logic        shutdown_o,
   input wire logic        reference_buffer_off_o,
   input wire logic        timing_core_run_o,
   input wire logic        clock_outputs_on_o,
   input wire logic [13:0] data_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Write taken on low byte lane
   wire wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
   wire [7:0] ix = wb_adr_i[9:2];
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   AST_GAIN_DB: assert property (1'b1 |=> gain_db_o ==
      19'($past(gain_code_o)) * ccd_pkg::GAIN_STEP + ccd_pkg::GAIN_BASE) else $error("gain dB");
   AST_PWR_EXCL: assert property (shutdown_o |-> !ref_standby_o) else $error("power");
   AST_PWR_WRITE: assert property (wr && ix == ccd_pkg::IDX_POWER |=> ##1
      shutdown_o == $past(wb_dat_i[1], 2) && reference_buffer_off_o == $past(wb_dat_i[2], 2)
      && ref_standby_o == ($past(wb_dat_i[1:0], 2) == 2'h1)) else $error("power write");
   AST_SOFT_CLEAR: assert property (wr && ix == ccd_pkg::IDX_SOFTRST && wb_dat_i[0] |=> ##1
      reference_buffer_off_o && !timing_core_run_o && !clock_outputs_on_o && gain_code_o == '0)
      else $error("soft clear");
   AST_CORE_STOP: assert property (wr && ix == ccd_pkg::IDX_CORE && !wb_dat_i[0]
      |=> ##1 !timing_core_run_o) else $error("core stop");
   AST_SHUT_ZERO: assert property (shutdown_o [*3] |-> data_o == '0)
      else $error("shutdown data");
   AST_STBY_ZERO: assert property ((ref_standby_o && !clock_outputs_on_o) [*3]
      |-> data_o == '0) else $error("standby data");
   AST_DRIVE_SYNC: assert property ($rose(clock_outputs_on_o)
      |-> !line_sync_i || !frame_sync_i) else $error("drive apply");
endmodule
bind ccd_frontend_mode_control ccd_frontend_mode_control_monitor u_mon (.*);

// ### bench/host_model.sv
module host_model (
   // Clock
   input  wire logic clk_i,
   // Sync and window pins, idle high sync
   output logic      line_sync_o  = 1'b1,
   output logic      frame_sync_o = 1'b1,
   output logic      window_o     = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   // Long pulses so the falls survive the input synchroniser
   task automatic sync(input logic frame);
      @(posedge clk_i);
      line_sync_o  <= 1'b0;
      frame_sync_o <= !frame;
      window_o     <= 1'b1;
      repeat (24) @(posedge clk_i);
      line_sync_o  <= 1'b1;
      frame_sync_o <= 1'b1;
      window_o     <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
endmodule

// ### bench/test_ccd_frontend_mode_control.sv
module test_ccd_frontend_mode_control;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [9:0] wb_adr_i = 10'h000, gain_code_o;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic wb_ack_o, line_sync_i, frame_sync_i, black_pixel_window_pulse_i;
   logic [13:0] adc_data_i = 14'h2aaa, data_o;
   logic [18:0] gain_db_o;
   logic signed [15:0] clamp_corr_o;
   logic ref_standby_o, shutdown_o, reference_buffer_off_o, timing_core_run_o, clock_outputs_on_o;
   logic [5:0] ref_sample_edge_pos_o, data_sample_edge_pos_o;
   logic [4:0] output_latch_phase_o;
   int num_errors = 0, num_checks = 0;
   ccd_frontend_mode_control u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .line_sync_i, .frame_sync_i,
      .black_pixel_window_pulse_i, .adc_data_i, .gain_code_o, .gain_db_o, .clamp_corr_o,
      .ref_sample_edge_pos_o, .data_sample_edge_pos_o, .output_latch_phase_o,
      .ref_standby_o, .shutdown_o, .reference_buffer_off_o, .timing_core_run_o,
      .clock_outputs_on_o, .data_o);
   host_model u_host (.clk_i, .line_sync_o(line_sync_i), .frame_sync_o(frame_sync_i),
      .window_o(black_pixel_window_pulse_i));
   initial forever #5 clk_i = ~clk_i;
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Classic cycle; ack is read before the edge's own updates land
   task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hf};
      wb_adr_i <= {ix, 2'b00};
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h0, 32'h1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task automatic rd(input logic [7:0] ix, input logic [31:0] e);
      bus(1'b0, ix, 32'h0);
      chk(q, e);
   endtask
   // Main sequence, writes made while syncs idle
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ccd_pkg::IDX_POWER, 32'hc);
      rd(ccd_pkg::IDX_EDGES, 32'h2000);
      rd(ccd_pkg::IDX_LATCH, 32'hf);
      rd(8'h3f, 32'h0);
      bus(1'b1, ccd_pkg::IDX_SOFTRST, 32'h1);
      rd(ccd_pkg::IDX_SOFTRST, 32'h0);
      bus(1'b1, ccd_pkg::IDX_EDGES, 32'h12505);
      bus(1'b1, ccd_pkg::IDX_LATCH, 32'h14);
      chk({ref_sample_edge_pos_o, data_sample_edge_pos_o,
         output_latch_phase_o}, 32'h2cb4);
      bus(1'b1, ccd_pkg::IDX_GAIN, 32'h3ff);
      bus(1'b1, ccd_pkg::IDX_OUTFMT, 32'h4);
      bus(1'b1, ccd_pkg::IDX_POWER, 32'h8);
      chk(reference_buffer_off_o, 32'h0);
      bus(1'b1, ccd_pkg::IDX_CORE, 32'h1);
      bus(1'b1, ccd_pkg::IDX_DRIVE, 32'h1);
      chk(clock_outputs_on_o, 32'h0);
      u_host.sync(1'b1);
      chk(clock_outputs_on_o, 32'h1);
      chk(gain_code_o, 32'h3ff);
      chk(gain_db_o, 32'h67736);
      chk(data_o, 32'(14'h2aaa ^ 14'h1555));
      rd(ccd_pkg::IDX_HCOUNT, 32'h11);
      bus(1'b1, ccd_pkg::IDX_POWER, 32'h9);
      repeat (2) @(posedge clk_i);
      chk(data_o, 32'h3fff);
      bus(1'b1, ccd_pkg::IDX_POWER, 32'ha);
      repeat (3) @(posedge clk_i);
      chk({shutdown_o, data_o}, 32'h4000);
      bus(1'b1, ccd_pkg::IDX_POWER, 32'h8);
      repeat (10000) @(posedge clk_i); // Settling wait before core restart
      bus(1'b1, ccd_pkg::IDX_CORE, 32'h0);
      bus(1'b1, ccd_pkg::IDX_CORE, 32'h1);
      chk(timing_core_run_o, 32'h1);
      bus(1'b1, ccd_pkg::IDX_TARGET, 32'h55);
      bus(1'b1, ccd_pkg::IDX_POWER, 32'h0);
      u_host.sync(1'b1);
      chk(clamp_corr_o, 32'h55);
      bus(1'b1, ccd_pkg::IDX_DRIVE, 32'h0);
      u_host.sync(1'b0);
      bus(1'b1, ccd_pkg::IDX_POWER, 32'h1);
      repeat (3) @(posedge clk_i);
      chk(data_o, 32'h0);
      bus(1'b1, ccd_pkg::IDX_SOFTRST, 32'h1);
      rd(ccd_pkg::IDX_POWER, 32'hc);
      rd(ccd_pkg::IDX_GAIN, 32'h0);
      chk(timing_core_run_o, 32'h0);
      give_verdict();
   end
   // Run needs about 102 us; allow ample margin
   initial begin
      #2ms;
      num_errors++;
      $display("ERROR %0t: timeout", $time);
      give_verdict();
   end
endmodule

// ### common/ccd_pkg.sv
package ccd_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_POWER   = 8'h00;
   localparam logic [7:0] IDX_OUTFMT  = 8'h01;
   localparam logic [7:0] IDX_SOFTRST = 8'h10;
   localparam logic [7:0] IDX_DRIVE   = 8'h11;
   localparam logic [7:0] IDX_CORE    = 8'h14;
   localparam logic [7:0] IDX_GAIN    = 8'h20;
   localparam logic [7:0] IDX_TARGET  = 8'h21;
   localparam logic [7:0] IDX_CLAMPDV = 8'h22;
   localparam logic [7:0] IDX_EDGES   = 8'h23;
   localparam logic [7:0] IDX_LATCH   = 8'h24;
   localparam logic [7:0] IDX_STATUS  = 8'h25;
   localparam logic [7:0] IDX_HCOUNT  = 8'h26;

   // Field positions
   localparam int POWER_LSB    = 0;
   localparam int REFBUF_BIT   = 2;
   localparam int LOOP_BIT     = 3;
   localparam int GRAY_BIT     = 2;
   localparam int SOFTRST_BIT  = 0;
   localparam int DRIVE_BIT    = 0;
   localparam int CORE_BIT     = 0;
   localparam int REF_EDGE_LSB = 0;
   localparam int DAT_EDGE_LSB = 8;
   localparam int SHA_BIT      = 16;

   // Widths
   localparam int GAIN_W  = 10;
   localparam int TGT_W   = 8;
   localparam int EDGE_W  = 6;
   localparam int ADC_W   = 14;
   localparam int HCNT_W  = 13;
   localparam int DIV_W   = 4;
   localparam int PHASE_W = 5;
   localparam int CORR_W  = 16;
   localparam int GDB_W   = 19;

   // Reset values
   localparam logic [1:0]         POWER_RST   = 2'h0;
   localparam logic               REFBUF_RST  = 1'b1;
   localparam logic               LOOP_RST    = 1'b1;
   localparam logic [GAIN_W-1:0]  GAIN_RST    = 10'h000;
   localparam logic [TGT_W-1:0]   TARGET_RST  = 8'h00;
   localparam logic [DIV_W-1:0]   CLAMPDV_RST = 4'h0;
   localparam logic [EDGE_W-1:0]  REF_EDGE_RST = 6'h00;
   localparam logic [EDGE_W-1:0]  DAT_EDGE_RST = 6'h20;
   localparam logic [PHASE_W-1:0] LATCH_RST   = 5'h0f;

   // Power state encodings
   localparam logic [1:0] PWR_FULL    = 2'h0;
   localparam logic [1:0] PWR_REF_SBY = 2'h1;

   // Sample edge offset required in differential sample mode
   localparam logic [EDGE_W-1:0] SHA_EDGE_OFS = 6'h20;

   // Gain in units of 0.1 milli-dB: 358 per code step plus 57500
   localparam logic [GDB_W-1:0] GAIN_STEP = 19'h00166;
   localparam logic [GDB_W-1:0] GAIN_BASE = 19'h0e09c;

   // Horizontal counter reset delay after the line sync fall
   localparam int HRESET_CYC = 12;
   // Cycles already spent in the two-flop synchroniser and edge detect
   localparam int SYNC_LAT   = 3;

endpackage

// ### hdl/black_clamp.sv
module black_clamp (
   // Clock and reset
   input  wire logic                              clk_i,
   input  wire logic                              rst_i,
   // Control
   input  wire logic                              run_i,
   input  wire logic                              loop_on_i,
   input  wire logic      [ccd_pkg::TGT_W-1:0]    target_i,
   input  wire logic      [ccd_pkg::DIV_W-1:0]    div_i,
   // Line timing and data
   input  wire logic                              window_i,
   input  wire logic                              line_start_i,
   input  wire logic      [ccd_pkg::ADC_W-1:0]    adc_i,
   // Correction to the DAC
   output logic signed    [ccd_pkg::CORR_W-1:0]   corr_o
);

   typedef struct packed {
      logic signed [ccd_pkg::CORR_W-1:0] avg;
      logic signed [ccd_pkg::CORR_W-1:0] corr;
      logic [ccd_pkg::DIV_W-1:0]         lines;
      logic                              win_prev;
   } cl_t;

   cl_t s_q;
   cl_t s_d;
   logic signed [ccd_pkg::CORR_W-1:0] err;

   // Error of each shielded pixel against the target
   assign err = $signed({2'b00, 6'h00, target_i}) - $signed({2'b00, adc_i}); // [RL3]

   // Average over the window, then one loop step per selected line
   always_comb begin
      s_d          = s_q;
      s_d.win_prev = window_i;
      if (window_i) begin
         s_d.avg = s_q.avg + ((err - s_q.avg) >>> 3); // [RL3]
      end
      if (line_start_i) begin
         s_d.lines = (s_q.lines == div_i) ? '0 : s_q.lines + 1'b1; // [RL5]
      end
      // Loop step at window end, on every (div+1)-th line
      if (s_q.win_prev && !window_i && s_q.lines == '0) begin
         s_d.corr = s_q.corr + (s_q.avg >>> 2); // [RL5]
      end
      // Open loop: target is a plain offset
      if (!loop_on_i) begin
         s_d.corr = $signed({8'h00, target_i}); // [RL4]
         s_d.avg  = '0;
      end
      if (!run_i) begin
         s_d.lines = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign corr_o = s_q.corr;

endmodule

// ### hdl/ccd_frontend_mode_control.sv
// Contract
// RL1 - Host sets data sample edge to reference edge plus 32 in differential mode.
// RL2 - Ten-bit gain code maps to 0.0358 dB per step plus 5.75 dB.
// RL3 - In shielded window, compare converter output to 0..255 target, feed back.
// RL4 - Black loop enable cleared: loop stops, target acts as fixed offset.
// RL5 - Clamp loop updates once per line, or less often when configured.
// RL6 - Host aligns black window with shielded pixels, ideally twenty pixels or longer.
// RL7 - Output words are straight binary, Gray coded when the Gray bit is set.
// RL8 - Host should set output latch phase between 15 and 31.
// RL9 - Soft register clear restores all defaults and clears itself.
// RL10 - Host start order: clock, clear, timing, power bits, core, drive.
// RL11 - Output drive enable applies at next frame or line sync fall.
// RL12 - Host keeps line sync fall at or after frame sync fall.
// RL13 - Line sync fall caught on master clock, then recaptured at reference phase.
// RL14 - Horizontal counter resets twelve clocks after the line sync fall.
// RL15 - Power field: 00 full, 01 reference standby, 1x total shutdown.
// RL16 - Drive enable beats reference standby; total shutdown beats drive enable.
// RL17 - Host restarts timing core at least 100 us after leaving shutdown.
// RL18 - Reference buffer off bit defaults set; clear it for normal operation.
// RL19 - Host restarts timing core with 0 then 1 after clock change.
// RL20 - After power-up, total shutdown drives data outputs low.
// RL21 - Host writes start-up registers with syncs idle.
// RL22 - Frame-synchronised settings take effect at next frame sync fall.
// RL23 - Restart bit low holds timing core in reset; rising starts it.
module ccd_frontend_mode_control (
   // Clock and reset
   input  wire logic                             clk_i,
   input  wire logic                             rst_i,
   // Wishbone classic slave
   input  wire logic                             wb_cyc_i,
   input  wire logic                             wb_stb_i,
   input  wire logic                             wb_we_i,
   input  wire logic      [9:0]                  wb_adr_i,
   input  wire logic      [3:0]                  wb_sel_i,
   input  wire logic      [31:0]                 wb_dat_i,
   output logic           [31:0]                 wb_dat_o,
   output logic                                  wb_ack_o,
   // Sync and window pins
   input  wire logic                             line_sync_i,
   input  wire logic                             frame_sync_i,
   input  wire logic                             black_pixel_window_pulse_i,
   // Converter data
   input  wire logic      [ccd_pkg::ADC_W-1:0]   adc_data_i,
   // Analog control
   output logic           [ccd_pkg::GAIN_W-1:0]  gain_code_o,
   output logic           [ccd_pkg::GDB_W-1:0]   gain_db_o,
   output logic signed    [ccd_pkg::CORR_W-1:0]  clamp_corr_o,
   output logic           [ccd_pkg::EDGE_W-1:0]  ref_sample_edge_pos_o,
   output logic           [ccd_pkg::EDGE_W-1:0]  data_sample_edge_pos_o,
   output logic           [ccd_pkg::PHASE_W-1:0] output_latch_phase_o,
   // Power and timing state
   output logic                                  ref_standby_o,
   output logic                                  shutdown_o,
   output logic                                  reference_buffer_off_o,
   output logic                                  timing_core_run_o,
   output logic                                  clock_outputs_on_o,
   // Output data
   output logic           [ccd_pkg::ADC_W-1:0]   data_o
);

   typedef struct packed {
      logic                          ack;
      logic [31:0]                   rdat;
      logic [1:0]                    pwr;
      logic                          refbuf_off;
      logic                          loop_on;
      logic                          gray_pend;
      logic                          gray_act;
      logic                          drive_pend;
      logic                          drive_act;
      logic                          core_run;
      logic [ccd_pkg::GAIN_W-1:0]    gain_pend;
      logic [ccd_pkg::GAIN_W-1:0]    gain_act;
      logic [ccd_pkg::TGT_W-1:0]     tgt_pend;
      logic [ccd_pkg::TGT_W-1:0]     tgt_act;
      logic [ccd_pkg::DIV_W-1:0]     clamp_div;
      logic [ccd_pkg::EDGE_W-1:0]    ref_edge;
      logic [ccd_pkg::EDGE_W-1:0]    data_edge;
      logic                          sha_mode;
      logic [ccd_pkg::PHASE_W-1:0]   latch_phase;
      logic [ccd_pkg::GDB_W-1:0]     gain_db;
      logic [ccd_pkg::ADC_W-1:0]     dout;
      logic [2:0]                    fs;
      logic [2:0]                    ls;
      logic [1:0]                    win;
      logic                          sby;
   } ctl_t;

   ctl_t s_q;
   ctl_t s_d;

   logic [ccd_pkg::HCNT_W-1:0] h_count;
   logic                       line_start;
   logic signed [ccd_pkg::CORR_W-1:0] corr;
   logic                       fs_fall;
   logic                       ls_fall;
   logic                       shut;
   logic                       sha_err;
   logic [31:0]                wmask;
   logic [31:0]                wval;
   logic [7:0]                 idx;
   logic                       wr;
   logic                       rd;

   // Sync edges; stage 0 is only read by stage 1
   assign fs_fall = s_q.fs[2] & ~s_q.fs[1];
   assign ls_fall = s_q.ls[2] & ~s_q.ls[1]; // [RL13]
   assign shut    = s_q.pwr[1];
   assign sha_err = s_q.sha_mode
                    && (s_q.data_edge != s_q.ref_edge + ccd_pkg::SHA_EDGE_OFS); // [RL1]

   // Bus decode; byte lanes build the write mask
   assign idx = wb_adr_i[9:2];
   assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & ~s_q.ack;
   assign rd  = wb_cyc_i & wb_stb_i & ~wb_we_i & ~s_q.ack;
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
      end
   endgenerate

   h_counter u_hcnt (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .run_i        (s_q.core_run),
      .line_fall_i  (ls_fall),
      .h_count_o    (h_count),
      .line_start_o (line_start)
   );

   black_clamp u_clamp (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .run_i        (s_q.core_run),
      .loop_on_i    (s_q.loop_on),
      .target_i     (s_q.tgt_act),
      .div_i        (s_q.clamp_div),
      .window_i     (s_q.win[1]),
      .line_start_i (line_start),
      .adc_i        (adc_data_i),
      .corr_o       (corr)
   );

   // Register file, sync capture and output path
   always_comb begin
      s_d      = s_q;
      wval     = 32'h0000_0000;
      s_d.ack  = wr | rd;
      s_d.rdat = 32'h0000_0000;
      s_d.fs   = {s_q.fs[1:0], frame_sync_i};
      s_d.ls   = {s_q.ls[1:0], line_sync_i};
      s_d.win  = {s_q.win[0], black_pixel_window_pulse_i};

      // Reads; unmapped indices answer with zero
      if (rd) begin
         if (idx == ccd_pkg::IDX_POWER) begin
            s_d.rdat[ccd_pkg::POWER_LSB +: 2] = s_q.pwr;
            s_d.rdat[ccd_pkg::REFBUF_BIT]     = s_q.refbuf_off;
            s_d.rdat[ccd_pkg::LOOP_BIT]       = s_q.loop_on;
         end else if (idx == ccd_pkg::IDX_OUTFMT) begin
            s_d.rdat[ccd_pkg::GRAY_BIT] = s_q.gray_pend;
         end else if (idx == ccd_pkg::IDX_DRIVE) begin
            s_d.rdat[ccd_pkg::DRIVE_BIT] = s_q.drive_pend;
         end else if (idx == ccd_pkg::IDX_CORE) begin
            s_d.rdat[ccd_pkg::CORE_BIT] = s_q.core_run;
         end else if (idx == ccd_pkg::IDX_GAIN) begin
            s_d.rdat[ccd_pkg::GAIN_W-1:0] = s_q.gain_pend;
         end else if (idx == ccd_pkg::IDX_TARGET) begin
            s_d.rdat[ccd_pkg::TGT_W-1:0] = s_q.tgt_pend;
         end else if (idx == ccd_pkg::IDX_CLAMPDV) begin
            s_d.rdat[ccd_pkg::DIV_W-1:0] = s_q.clamp_div;
         end else if (idx == ccd_pkg::IDX_EDGES) begin
            s_d.rdat[ccd_pkg::REF_EDGE_LSB +: ccd_pkg::EDGE_W] = s_q.ref_edge;
            s_d.rdat[ccd_pkg::DAT_EDGE_LSB +: ccd_pkg::EDGE_W] = s_q.data_edge;
            s_d.rdat[ccd_pkg::SHA_BIT]                         = s_q.sha_mode;
         end else if (idx == ccd_pkg::IDX_LATCH) begin
            s_d.rdat[ccd_pkg::PHASE_W-1:0] = s_q.latch_phase;
         end else if (idx == ccd_pkg::IDX_STATUS) begin
            s_d.rdat[3:0] = {sha_err, s_q.gray_act, s_q.drive_act, s_q.core_run};
            s_d.rdat[31:16] = corr;
         end else if (idx == ccd_pkg::IDX_HCOUNT) begin
            s_d.rdat[ccd_pkg::HCNT_W-1:0] = h_count;
         end
      end

      // Frame-synchronised settings move over at the frame sync fall
      if (fs_fall) begin
         s_d.gain_act = s_q.gain_pend; // [RL22]
         s_d.tgt_act  = s_q.tgt_pend;  // [RL22]
         s_d.gray_act = s_q.gray_pend; // [RL22]
      end
      // Drive enable waits for either sync fall to avoid a split line
      if (fs_fall || ls_fall) begin
         s_d.drive_act = s_q.drive_pend; // [RL11]
      end

      // Writes; bytes outside sel keep their old value
      if (wr) begin
         wval = wb_dat_i & wmask;
         if (idx == ccd_pkg::IDX_POWER) begin
            if (wb_sel_i[0]) begin
               s_d.pwr        = wval[ccd_pkg::POWER_LSB +: 2]; // [RL15]
               s_d.refbuf_off = wval[ccd_pkg::REFBUF_BIT];     // [RL18]
               s_d.loop_on    = wval[ccd_pkg::LOOP_BIT];       // [RL4]
            end
         end else if (idx == ccd_pkg::IDX_OUTFMT) begin
            if (wb_sel_i[0]) begin
               s_d.gray_pend = wval[ccd_pkg::GRAY_BIT]; // [RL7]
            end
         end else if (idx == ccd_pkg::IDX_DRIVE) begin
            if (wb_sel_i[0]) begin
               s_d.drive_pend = wval[ccd_pkg::DRIVE_BIT];
            end
         end else if (idx == ccd_pkg::IDX_CORE) begin
            if (wb_sel_i[0]) begin
               s_d.core_run = wval[ccd_pkg::CORE_BIT]; // [RL23]
            end
         end else if (idx == ccd_pkg::IDX_GAIN) begin
            s_d.gain_pend = (s_q.gain_pend & ~wmask[ccd_pkg::GAIN_W-1:0])
                            | wval[ccd_pkg::GAIN_W-1:0];
         end else if (idx == ccd_pkg::IDX_TARGET) begin
            if (wb_sel_i[0]) begin
               s_d.tgt_pend = wval[ccd_pkg::TGT_W-1:0];
            end
         end else if (idx == ccd_pkg::IDX_CLAMPDV) begin
            if (wb_sel_i[0]) begin
               s_d.clamp_div = wval[ccd_pkg::DIV_W-1:0];
            end
         end else if (idx == ccd_pkg::IDX_EDGES) begin
            if (wb_sel_i[0]) begin
               s_d.ref_edge = wval[ccd_pkg::REF_EDGE_LSB +: ccd_pkg::EDGE_W];
            end
            if (wb_sel_i[1]) begin
               s_d.data_edge = wval[ccd_pkg::DAT_EDGE_LSB +: ccd_pkg::EDGE_W];
            end
            if (wb_sel_i[2]) begin
               s_d.sha_mode = wval[ccd_pkg::SHA_BIT];
            end
         end else if (idx == ccd_pkg::IDX_LATCH) begin
            if (wb_sel_i[0]) begin
               s_d.latch_phase = wval[ccd_pkg::PHASE_W-1:0];
            end
         end else if (idx == ccd_pkg::IDX_SOFTRST) begin
            // Self-clearing: nothing stores the bit, so it reads zero
            if (wval[ccd_pkg::SOFTRST_BIT]) begin
               s_d.pwr         = ccd_pkg::POWER_RST; // [RL9]
               s_d.refbuf_off  = ccd_pkg::REFBUF_RST;
               s_d.loop_on     = ccd_pkg::LOOP_RST;
               s_d.gray_pend   = 1'b0;
               s_d.gray_act    = 1'b0;
               s_d.drive_pend  = 1'b0;
               s_d.drive_act   = 1'b0;
               s_d.core_run    = 1'b0;
               s_d.gain_pend   = ccd_pkg::GAIN_RST;
               s_d.gain_act    = ccd_pkg::GAIN_RST;
               s_d.tgt_pend    = ccd_pkg::TARGET_RST;
               s_d.tgt_act     = ccd_pkg::TARGET_RST;
               s_d.clamp_div   = ccd_pkg::CLAMPDV_RST;
               s_d.ref_edge    = ccd_pkg::REF_EDGE_RST;
               s_d.data_edge   = ccd_pkg::DAT_EDGE_RST;
               s_d.sha_mode    = 1'b0;
               s_d.latch_phase = ccd_pkg::LATCH_RST;
            end
         end
      end

      // Gain in 0.1 milli-dB, linear in code
      s_d.gain_db = gdb(s_q.gain_act); // [RL2]
      s_d.sby     = (s_d.pwr == ccd_pkg::PWR_REF_SBY); // [RL15]

      // Output priority: shutdown, then drive enable, then standby
      if (shut) begin
         s_d.dout = '0; // [RL20] [RL16]
      end else if (!s_q.drive_act && s_q.pwr == ccd_pkg::PWR_REF_SBY) begin
         s_d.dout = '0; // [RL16]
      end else if (s_q.gray_act) begin
         s_d.dout = adc_data_i ^ (adc_data_i >> 1); // [RL7]
      end else begin
         s_d.dout = adc_data_i;
      end
   end

   function automatic logic [ccd_pkg::GDB_W-1:0] gdb(input logic [ccd_pkg::GAIN_W-1:0] c);
      logic [2*ccd_pkg::GDB_W-1:0] p;
      p   = ccd_pkg::GAIN_STEP * {9'h000, c};
      gdb = p[ccd_pkg::GDB_W-1:0] + ccd_pkg::GAIN_BASE;
   endfunction

   // Register stage; reset values match the soft clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q             <= '0;
         s_q.refbuf_off  <= ccd_pkg::REFBUF_RST; // [RL18]
         s_q.loop_on     <= ccd_pkg::LOOP_RST;
         s_q.pwr         <= ccd_pkg::POWER_RST;
         s_q.data_edge   <= ccd_pkg::DAT_EDGE_RST;
         s_q.latch_phase <= ccd_pkg::LATCH_RST;
         s_q.gain_db     <= ccd_pkg::GAIN_BASE;
      end else begin
         s_q <= s_d;
      end
   end

   // Top outputs straight from flops
   assign wb_ack_o               = s_q.ack;
   assign wb_dat_o               = s_q.rdat;
   assign gain_code_o            = s_q.gain_act;
   assign gain_db_o              = s_q.gain_db;
   assign clamp_corr_o           = corr;
   assign ref_sample_edge_pos_o  = s_q.ref_edge;
   assign data_sample_edge_pos_o = s_q.data_edge;
   assign output_latch_phase_o   = s_q.latch_phase;
   assign ref_standby_o          = s_q.sby;
   assign shutdown_o             = s_q.pwr[1]; // [RL15]
   assign reference_buffer_off_o = s_q.refbuf_off;
   assign timing_core_run_o      = s_q.core_run;
   assign clock_outputs_on_o     = s_q.drive_act; // [RL11]
   assign data_o                 = s_q.dout;

endmodule

// ### hdl/h_counter.sv
module h_counter (
   // Clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   // Control
   input  wire logic                      run_i,
   input  wire logic                      line_fall_i,
   // Status
   output logic      [ccd_pkg::HCNT_W-1:0] h_count_o,
   output logic                           line_start_o
);

   typedef enum logic [0:0] {
      HC_FREE = 1'b0,
      HC_WAIT = 1'b1
   } hc_state_t;

   typedef struct packed {
      hc_state_t                 st;
      logic [3:0]                dly;
      logic [ccd_pkg::HCNT_W-1:0] cnt;
      logic                      start;
   } hc_t;

   localparam logic [3:0] WAIT_CYC = 4'(ccd_pkg::HRESET_CYC - ccd_pkg::SYNC_LAT);

   hc_t s_q;
   hc_t s_d;

   // Delay line from the edge to the counter reset
   always_comb begin
      s_d       = s_q;
      s_d.start = 1'b0;
      s_d.cnt   = s_q.cnt + 1'b1;
      case (s_q.st)
         HC_FREE: begin
            if (line_fall_i) begin
               s_d.st  = HC_WAIT;
               s_d.dly = WAIT_CYC - 4'h1;
            end
         end
         HC_WAIT: begin
            if (s_q.dly == 4'h0) begin
               s_d.st    = HC_FREE;
               s_d.cnt   = '0; // [RL14]
               s_d.start = 1'b1;
            end else begin
               s_d.dly = s_q.dly - 4'h1;
            end
         end
         default: s_d.st = HC_FREE;
      endcase
      // Stopped core holds the counter in its initial state
      if (!run_i) begin
         s_d = '0; // [RL23]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign h_count_o    = s_q.cnt;
   assign line_start_o = s_q.start;

endmodule
